// file: design/rms_top.sv
// Purpose: Reset sequencing and operating mode selection with APB status and control.
// Assumes: presetn is the power-on reset; brownout_in is a level from the supply monitor.
// Notes:   Mode is chosen once per system reset and held until the next one.
//
// Functional notes
// RULE1: Straps decode: 11 normal, 01 programming, 10 debug, 00 production test.
// RULE2: Normal mode boots from flash address 4000 hexadecimal.
// RULE3: Programming, debug and test hand control to ROM firmware and I2C master.
// RULE4: Board must never hold both straps low at power-on.
// RULE5: Strap pull-ups are enabled from power-on reset.
// RULE6: With sector lock set, every strap choice except test selects normal.
// RULE7: With sector lock set, write, erase and read of sector 0 are blocked.
// RULE8: Power-on, brown-out and software reset each lead to a new mode selection.
// RULE9: Internal blocks stay in reset while brown-out is indicated.
// RULE10: Writing the software reset bit forces a full reset and mode selection.
// RULE11: After the release delay the straps are sampled over a window, then run.
// RULE12: Board must hold straps constant during the whole sampling window.
// RULE13: Watchdog reset restarts only the CPU without mode selection.
// RULE14: Wakeup or watchdog passes through init straight to run, no selection.
// RULE15: Latched mode holds until the next power-on, brown-out or software reset.
`timescale 1ns/1ps
`default_nettype none
module rms_top
    import rms_pkg::*;
#(
    parameter int POR_DELAY_CYCLES = T_POR_US * CLK_MHZ
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata_r,
    output logic             pready_r,
    output logic             pslverr_r,
    input  wire logic        mode_strap_a,
    input  wire logic        mode_strap_b,
    input  wire logic        brownout_in,
    input  wire logic        sector_lock_in,
    input  wire logic        watchdog_timeout,
    input  wire logic        wakeup_event,
    input  wire logic        flash_op_valid,
    input  wire logic        flash_op_sector0,
    output logic             flash_op_allow_r,
    output logic             flash_op_block_r,
    output logic             flash_sector0_lock_r,
    output logic             strap_pullup_en_r,
    output logic             sys_rst_n_r,
    output logic             cpu_rst_n_r,
    output logic [1:0]       mode_r,
    output logic             mode_valid_r,
    output logic             rom_control_r,
    output logic             i2c_slave_en_r,
    output logic [15:0]      boot_addr_r
);
    // ------------------------------------------------------------------
    // APB slave
    // ------------------------------------------------------------------
    logic        acc;
    logic        wr_fire;
    logic [31:0] prdata_nxt;
    logic        pready_nxt;
    logic        pslverr_nxt;
    logic        swrst_req;
    logic [4:0]  cause_r;
    logic [4:0]  cause_nxt;
    logic        deny_r;
    logic        deny_nxt;

    // Sequencer results are also shown in STATUS.
    logic        unstable_r;
    logic [1:0]  straps_r;
    rms_state_e  state_r;
    rms_state_e  state_nxt;

    // One wait state: pready rises in the second access cycle, so the
    // read data and error flag can come straight from flops.
    assign acc     = psel && penable;
    assign wr_fire = acc && pready_r && pwrite;

    always_comb begin
        pready_nxt  = acc && !pready_r;
        prdata_nxt  = 32'h0000_0000;
        pslverr_nxt = 1'b0;
        swrst_req   = 1'b0;
        // Unmapped offsets answer with an error.
        if (acc && !pready_r) begin
            if (paddr == CTRL_OFS) begin
                // The reset bit clears itself.
                prdata_nxt = 32'h0000_0000;
            end else if (paddr == STATUS_OFS) begin
                prdata_nxt[ST_MODE_LSB +: 2]  = mode_r;
                prdata_nxt[ST_VALID_BIT]      = mode_valid_r;
                prdata_nxt[ST_LOCK_BIT]       = flash_sector0_lock_r;
                prdata_nxt[ST_UNSTAB_BIT]     = unstable_r;
                prdata_nxt[ST_STATE_LSB +: 3] = state_r;
                prdata_nxt[ST_DENY_BIT]       = deny_r;
            end else if (paddr == CAUSE_OFS) begin
                prdata_nxt[4:0] = cause_r;
            end else begin
                pslverr_nxt = 1'b1;
            end
        end

        // RULE10: software reset bit
        if (wr_fire && (paddr == CTRL_OFS) && pwdata[CTRL_SWRST_BIT]) begin
            swrst_req = 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_r  <= 32'h0000_0000;
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
        end else begin
            prdata_r  <= prdata_nxt;
            pready_r  <= pready_nxt;
            pslverr_r <= pslverr_nxt;
        end
    end

    // ------------------------------------------------------------------
    // Reset sequencer
    // ------------------------------------------------------------------
    rms_timer_if tmr ();

    logic        smp_start;
    logic        tmr_load;
    logic [TMR_W-1:0] tmr_count;
    logic        sys_rst_n_nxt;
    logic        cpu_rst_n_nxt;
    logic [1:0]  mode_nxt;
    logic        mode_valid_nxt;
    logic        rom_ctl_nxt;
    logic        i2c_en_nxt;
    logic [15:0] boot_nxt;
    logic        lock_nxt;

    rms_mode_e   sel_mode;

    assign tmr.load  = tmr_load;
    assign tmr.count = tmr_count;

    // One timer serves both the delay and the window.
    rms_timer u_timer (
        .pclk    (pclk),
        .presetn (presetn),
        .tif     (tmr)
    );

    // A strap change in the window is flagged, not acted on.
    rms_strap_sampler u_sampler (
        .pclk       (pclk),
        .presetn    (presetn),
        .start      (smp_start),
        .active     (state_r == RMS_ST_SAMPLE),
        .strap_a    (mode_strap_a),
        .strap_b    (mode_strap_b),
        .straps_r   (straps_r),
        .unstable_r (unstable_r)
    );

    // RULE1: strap decode with lock folding
    // RULE6: lock forces normal mode
    assign sel_mode = rms_decode(straps_r[1], straps_r[0], sector_lock_in);

    always_comb begin
        state_nxt      = state_r;
        tmr_load       = 1'b0;
        tmr_count      = '0;
        smp_start      = 1'b0;
        mode_nxt       = mode_r;
        mode_valid_nxt = mode_valid_r;
        rom_ctl_nxt    = rom_control_r;
        i2c_en_nxt     = i2c_slave_en_r;
        boot_nxt       = boot_addr_r;
        case (state_r)
            RMS_ST_HOLD: begin
                // RULE9: held while brown-out
                if (!brownout_in) begin
                    tmr_load  = 1'b1;
                    tmr_count = TMR_W'(POR_DELAY_CYCLES);
                    state_nxt = RMS_ST_DELAY;
                end
            end

            RMS_ST_DELAY: begin
                // RULE11: sample window after delay
                if (tmr.expired) begin
                    tmr_load  = 1'b1;
                    tmr_count = TMR_W'(T_MODE_CYC);
                    // Straps are caught on the reload edge.
                    smp_start = 1'b1;
                    state_nxt = RMS_ST_SAMPLE;
                end
            end

            RMS_ST_SAMPLE: begin
                if (tmr.expired) begin
                    mode_nxt       = sel_mode;
                    mode_valid_nxt = 1'b1;

                    // RULE2: normal boots from flash
                    // RULE3: other modes go to ROM
                    rom_ctl_nxt    = (sel_mode != RMS_MODE_NORMAL);
                    i2c_en_nxt     = (sel_mode != RMS_MODE_NORMAL);
                    boot_nxt       = (sel_mode == RMS_MODE_NORMAL) ? FLASH_BOOT : ROM_BOOT;
                    state_nxt      = RMS_ST_RUN;
                end
            end

            RMS_ST_RUN: begin
                // Mode and boot address stay latched.
                // RULE13: watchdog restarts CPU only
                // RULE14: wakeup passes init to run
                if (watchdog_timeout || wakeup_event) begin
                    state_nxt = RMS_ST_RESTART;
                end
            end

            RMS_ST_RESTART: begin
                // One cycle of CPU reset, then run again.
                state_nxt = RMS_ST_RUN;
            end

            default: begin
                state_nxt = RMS_ST_HOLD;
            end
        endcase

        // Brown-out and software reset win over any state.
        // RULE8: new selection after each reset
        // RULE15: mode valid flag cleared only here; mode_r keeps its value
        if (brownout_in || swrst_req) begin
            state_nxt      = RMS_ST_HOLD;
            tmr_load       = 1'b0;
            smp_start      = 1'b0;
            mode_valid_nxt = 1'b0;
            rom_ctl_nxt    = 1'b0;
            i2c_en_nxt     = 1'b0;
        end

        // On a restart only the CPU reset falls.
        sys_rst_n_nxt = (state_nxt == RMS_ST_RUN) || (state_nxt == RMS_ST_RESTART);
        cpu_rst_n_nxt = (state_nxt == RMS_ST_RUN);
    end

    // Reset values select normal mode from flash.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r        <= RMS_ST_HOLD;
            sys_rst_n_r    <= 1'b0;
            cpu_rst_n_r    <= 1'b0;
            mode_r         <= RMS_MODE_NORMAL;
            mode_valid_r   <= 1'b0;
            rom_control_r  <= 1'b0;
            i2c_slave_en_r <= 1'b0;
            boot_addr_r    <= FLASH_BOOT;
        end else begin
            state_r        <= state_nxt;
            sys_rst_n_r    <= sys_rst_n_nxt;
            cpu_rst_n_r    <= cpu_rst_n_nxt;
            mode_r         <= mode_nxt;
            mode_valid_r   <= mode_valid_nxt;
            rom_control_r  <= rom_ctl_nxt;
            i2c_slave_en_r <= i2c_en_nxt;
            boot_addr_r    <= boot_nxt;
        end
    end

    // ------------------------------------------------------------------
    // Reset cause, flash guard and strap pull-ups
    // ------------------------------------------------------------------
    logic allow_nxt;
    logic block_nxt;
    logic cause_w1c;

    // Registered so the guard and STATUS agree.
    assign lock_nxt  = sector_lock_in;
    assign cause_w1c = wr_fire && (paddr == CAUSE_OFS);

    always_comb begin
        cause_nxt = cause_r;
        deny_nxt  = deny_r;
        // Clear first so that a cause arriving in the same cycle survives.
        if (cause_w1c) begin
            cause_nxt = cause_r & ~pwdata[4:0];
        end

        if (wr_fire && (paddr == STATUS_OFS) && pwdata[ST_DENY_BIT]) begin
            deny_nxt = 1'b0;
        end

        // Brown-out is logged only if it cuts a sequence.
        if (brownout_in && (state_r != RMS_ST_HOLD)) begin
            cause_nxt[CA_BOR_BIT] = 1'b1;
        end

        if (swrst_req) begin
            cause_nxt[CA_SWR_BIT] = 1'b1;
        end

        if ((state_r == RMS_ST_RUN) && watchdog_timeout) begin
            cause_nxt[CA_WDT_BIT] = 1'b1;
        end

        if ((state_r == RMS_ST_RUN) && wakeup_event) begin
            cause_nxt[CA_WAKE_BIT] = 1'b1;
        end

        // RULE7: sector 0 guard
        block_nxt = flash_op_valid && flash_op_sector0 && flash_sector0_lock_r;
        allow_nxt = flash_op_valid && !block_nxt;

        if (block_nxt) begin
            deny_nxt = 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cause_r              <= CAUSE_RST;
            deny_r               <= 1'b0;
            flash_op_allow_r     <= 1'b0;
            flash_op_block_r     <= 1'b0;
            flash_sector0_lock_r <= 1'b0;
            strap_pullup_en_r    <= 1'b1;
        end else begin
            cause_r              <= cause_nxt;
            deny_r               <= deny_nxt;
            flash_op_allow_r     <= allow_nxt;
            flash_op_block_r     <= block_nxt;
            flash_sector0_lock_r <= lock_nxt;

            // RULE5: pull-ups on from reset
            strap_pullup_en_r    <= 1'b1;
        end
    end
endmodule : rms_top
`default_nettype wire

// file: design/rms_pkg.sv
// Purpose: Shared constants and types for the reset and mode selection block.
// Assumes: 10 MHz pclk, 32-bit APB register bus.
// Notes:   Strap pair {a,b} is used directly as the mode code.
`default_nettype none
package rms_pkg;
    localparam int          CLK_MHZ        = 10;
    // Settling times in microseconds, converted to pclk cycles below.
    localparam int          T_POR_US       = 1000;
    localparam int          T_MODE_US      = 100;
    localparam int          T_MODE_CYC     = (T_MODE_US * CLK_MHZ < 1) ? 1 : T_MODE_US * CLK_MHZ;
    localparam int          TMR_W          = 16;

    // Register byte offsets.
    localparam logic [11:0] CTRL_OFS       = 12'h000;
    localparam logic [11:0] STATUS_OFS     = 12'h004;
    localparam logic [11:0] CAUSE_OFS      = 12'h008;

    // Field positions.
    localparam int          CTRL_SWRST_BIT = 0;
    localparam int          ST_MODE_LSB    = 0;
    localparam int          ST_VALID_BIT   = 2;
    localparam int          ST_LOCK_BIT    = 3;
    localparam int          ST_UNSTAB_BIT  = 4;
    localparam int          ST_STATE_LSB   = 5;
    localparam int          ST_DENY_BIT    = 8;
    localparam int          CA_POR_BIT     = 0;
    localparam int          CA_BOR_BIT     = 1;
    localparam int          CA_SWR_BIT     = 2;
    localparam int          CA_WDT_BIT     = 3;
    localparam int          CA_WAKE_BIT    = 4;
    localparam logic [4:0]  CAUSE_RST      = 5'h01;

    // Boot addresses; the ROM entry value is arbitrary.
    localparam logic [15:0] FLASH_BOOT     = 16'h4000;
    localparam logic [15:0] ROM_BOOT       = 16'h0000;

    typedef enum logic [1:0] {
        RMS_MODE_TEST   = 2'h0,
        RMS_MODE_PROG   = 2'h1,
        RMS_MODE_DEBUG  = 2'h2,
        RMS_MODE_NORMAL = 2'h3
    } rms_mode_e;

    // Gray codes along hold, delay, sample, run.
    typedef enum logic [2:0] {
        RMS_ST_HOLD    = 3'h0,
        RMS_ST_DELAY   = 3'h1,
        RMS_ST_SAMPLE  = 3'h3,
        RMS_ST_RUN     = 3'h2,
        RMS_ST_RESTART = 3'h6
    } rms_state_e;

    // Strap pair to mode, with the sector lock folding all but test to normal.
    function automatic rms_mode_e rms_decode(input logic strap_a, input logic strap_b, input logic lock);
        rms_mode_e m;
        m = rms_mode_e'({strap_a, strap_b});
        if (lock && (m != RMS_MODE_TEST)) begin
            m = RMS_MODE_NORMAL;
        end
        return m;
    endfunction : rms_decode
endpackage : rms_pkg
`default_nettype wire

// file: design/rms_timer_if.sv
// Purpose: Load and expiry handshake between the sequencer and its delay timer.
// Assumes: Single pclk domain.
// Notes:   load is a one-cycle pulse; expired is a one-cycle pulse.
`timescale 1ns/1ps
`default_nettype none
interface rms_timer_if;
    import rms_pkg::*;
    logic             load;
    logic [TMR_W-1:0] count;
    logic             expired;
    modport ctrl  (output load, output count, input expired);
    modport timer (input load, input count, output expired);
endinterface : rms_timer_if
`default_nettype wire

// file: design/rms_timer.sv
// Purpose: Down counter that flags the end of a loaded delay.
// Assumes: Loaded count is at least one.
// Notes:   expired pulses in the cycle the count reaches zero.
`timescale 1ns/1ps
`default_nettype none
module rms_timer
    import rms_pkg::*;
(
    input  wire logic  pclk,
    input  wire logic  presetn,
    rms_timer_if.timer tif
);
    logic [TMR_W-1:0] cnt_r;
    logic [TMR_W-1:0] cnt_nxt;
    logic             exp_r;
    logic             exp_nxt;

    always_comb begin
        cnt_nxt = cnt_r;
        exp_nxt = 1'b0;
        if (tif.load) begin
            cnt_nxt = tif.count;
        end else if (cnt_r != '0) begin
            cnt_nxt = cnt_r - 1'b1;
            exp_nxt = (cnt_r == TMR_W'(1));
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_r <= '0;
            exp_r <= 1'b0;
        end else begin
            cnt_r <= cnt_nxt;
            exp_r <= exp_nxt;
        end
    end

    assign tif.expired = exp_r;
endmodule : rms_timer
`default_nettype wire

// file: design/rms_strap_sampler.sv
// Purpose: Watches the strap pair across the mode sampling window.
// Assumes: Straps are synchronous to pclk.
// Notes:   The value caught at start is kept; any change while active sets unstable.
`timescale 1ns/1ps
`default_nettype none
module rms_strap_sampler (
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       start,
    input  wire logic       active,
    input  wire logic       strap_a,
    input  wire logic       strap_b,
    output logic [1:0]      straps_r,
    output logic            unstable_r
);
    logic [1:0] straps_nxt;
    logic       unstable_nxt;

    always_comb begin
        straps_nxt   = straps_r;
        unstable_nxt = unstable_r;
        if (start) begin
            straps_nxt   = {strap_a, strap_b};
            unstable_nxt = 1'b0;
        end else if (active && ({strap_a, strap_b} != straps_r)) begin
            unstable_nxt = 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            straps_r   <= 2'h3;
            unstable_r <= 1'b0;
        end else begin
            straps_r   <= straps_nxt;
            unstable_r <= unstable_nxt;
        end
    end
endmodule : rms_strap_sampler
`default_nettype wire

// file: sim/rms_strap_board.sv
// Purpose: Board side of the strap pins: jumpers that drive a level or are left open.
// Assumes: Straps are steady levels; no I2C traffic is modelled at these ports.
// Notes:   An open strap reads its pull-up when enabled, else the inverse of level.
`timescale 1ns/1ps
`default_nettype none
module rms_strap_board (
    input  wire logic       pullup_en,
    input  wire logic       drive_en,
    input  wire logic [1:0] level,
    output logic            strap_a,
    output logic            strap_b
);
    // -----------------------------------------------
    // Strap wires
    // -----------------------------------------------
    // levels change only on request.
    // open pins follow the pull-up.
    // Without a pull-up an open pin shows the inverse, so a lost pull-up reads high wherever level is low.
    assign strap_a = drive_en ? level[1] : (pullup_en ? 1'b1 : ~level[1]);
    assign strap_b = drive_en ? level[0] : (pullup_en ? 1'b1 : ~level[0]);
endmodule : rms_strap_board
`default_nettype wire

// file: sim/rms_top_sva.sv
// Purpose: Port level checks of reset sequencing and mode selection.
// Assumes: One pclk domain, presetn async active low.
// Notes:   Bound into rms_top after the module.
`timescale 1ns/1ps
`default_nettype none
module rms_top_sva
    import rms_pkg::*;
(
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        brownout_in,
    input wire logic        watchdog_timeout,
    input wire logic        wakeup_event,
    input wire logic        flash_op_valid,
    input wire logic        flash_op_sector0,
    input wire logic        flash_op_allow_r,
    input wire logic        flash_op_block_r,
    input wire logic        flash_sector0_lock_r,
    input wire logic        strap_pullup_en_r,
    input wire logic        sys_rst_n_r,
    input wire logic        cpu_rst_n_r,
    input wire logic [1:0]  mode_r,
    input wire logic        mode_valid_r,
    input wire logic        rom_control_r,
    input wire logic        i2c_slave_en_r,
    input wire logic [15:0] boot_addr_r
);
    // -----------------------------------------------
    // Properties
    // -----------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_restart_req;
        (watchdog_timeout || wakeup_event) && sys_rst_n_r && cpu_rst_n_r && !brownout_in;
    endsequence
    sequence s_cpu_pulse;
        !cpu_rst_n_r && sys_rst_n_r && $stable(mode_r) ##1 cpu_rst_n_r && mode_valid_r;
    endsequence

    chk_pullup_on: assert property (strap_pullup_en_r)
        else $error("strap pull-up not enabled");
    chk_boot_addr: assert property (mode_valid_r |-> boot_addr_r == ((mode_r == 2'h3) ? 16'h4000 : 16'h0000))
        else $error("boot address does not match mode");
    chk_rom_owner: assert property (mode_valid_r |-> rom_control_r == (mode_r != 2'h3) && i2c_slave_en_r == rom_control_r)
        else $error("ROM control does not match mode");
    chk_brownout_hold: assert property (brownout_in |=> !sys_rst_n_r && !mode_valid_r)
        else $error("blocks not held in reset during brown-out");
    chk_mode_held: assert property ($past(mode_valid_r) && mode_valid_r |-> $stable(mode_r))
        else $error("latched mode changed");
    chk_run_after: assert property (sys_rst_n_r |-> mode_valid_r)
        else $error("released before mode selection");
    chk_flash_block: assert property (flash_op_valid && flash_op_sector0 && flash_sector0_lock_r
        |=> flash_op_block_r && !flash_op_allow_r)
        else $error("locked sector 0 access not blocked");
    chk_flash_allow: assert property (flash_op_valid && !(flash_op_sector0 && flash_sector0_lock_r)
        |=> flash_op_allow_r && !flash_op_block_r)
        else $error("unlocked flash access not allowed");
    chk_cpu_restart: assert property (s_restart_req |=> s_cpu_pulse)
        else $error("watchdog or wakeup restart wrong");
endmodule : rms_top_sva
bind rms_top rms_top_sva u_rms_top_sva (.pclk(pclk), .presetn(presetn), .brownout_in(brownout_in),
    .watchdog_timeout(watchdog_timeout), .wakeup_event(wakeup_event), .flash_op_valid(flash_op_valid),
    .flash_op_sector0(flash_op_sector0), .flash_op_allow_r(flash_op_allow_r), .flash_op_block_r(flash_op_block_r),
    .flash_sector0_lock_r(flash_sector0_lock_r), .strap_pullup_en_r(strap_pullup_en_r), .sys_rst_n_r(sys_rst_n_r),
    .cpu_rst_n_r(cpu_rst_n_r), .mode_r(mode_r), .mode_valid_r(mode_valid_r), .rom_control_r(rom_control_r),
    .i2c_slave_en_r(i2c_slave_en_r), .boot_addr_r(boot_addr_r));
`default_nettype wire

// file: sim/rms_top_test.sv
// Purpose: Self-checking bench for reset sources, mode selection and flash lock.
// Assumes: pclk 10 MHz, short power-on delay parameter.
// Notes:   Straps change only outside the sampling window unless a scenario says so.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin cmp_count++; if ((got) !== (ex)) begin bad_count++; \
    $display("MISMATCH %s exp %0h got %0h", nm, ex, got); end end
module rms_top_test
    import rms_pkg::*;
;
    // -----------------------------------------------
    // Stimulus and checks
    // -----------------------------------------------
    localparam int POR_CYC = 20;
    logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata_r, rd;
    logic        pready_r, pslverr_r, err, sa, sb, bo = 1'b0, lock = 1'b0, wd = 1'b0, wk = 1'b0;
    logic        fv = 1'b0, fs = 1'b0, allow, block, lk_r, pu, sys_n, cpu_n, vld, romc, i2c, drv = 1'b1;
    logic [1:0]  lvl = 2'h3, mode, em;
    logic [15:0] boot;
    int          bad_count = 0, cmp_count = 0, n;

    always #50 pclk = ~pclk;

    rms_top #(.POR_DELAY_CYCLES(POR_CYC)) u_rms_top (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata_r(prdata_r),
        .pready_r(pready_r), .pslverr_r(pslverr_r), .mode_strap_a(sa), .mode_strap_b(sb), .brownout_in(bo),
        .sector_lock_in(lock), .watchdog_timeout(wd), .wakeup_event(wk), .flash_op_valid(fv),
        .flash_op_sector0(fs), .flash_op_allow_r(allow), .flash_op_block_r(block), .flash_sector0_lock_r(lk_r),
        .strap_pullup_en_r(pu), .sys_rst_n_r(sys_n), .cpu_rst_n_r(cpu_n), .mode_r(mode), .mode_valid_r(vld),
        .rom_control_r(romc), .i2c_slave_en_r(i2c), .boot_addr_r(boot));
    rms_strap_board u_rms_strap_board (.pullup_en(pu), .drive_en(drv), .level(lvl), .strap_a(sa), .strap_b(sb));

    task automatic final_report();
        $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : final_report

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge pclk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin @(posedge pclk); k++; end while (pready_r !== 1'b1 && k < 50);
        if (pready_r !== 1'b1) bad_count++;
        rd = prdata_r;
        err = pslverr_r;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wait_valid();
        n = 0;
        while (vld !== 1'b1 && n < 3000) begin @(posedge pclk); n++; end
        @(negedge pclk);
    endtask : wait_valid

    task automatic check_mode(input logic [1:0] e);
        `CHK("mode", e, mode)
        `CHK("boot_addr", (e == 2'h3) ? 16'h4000 : 16'h0000, boot)
        `CHK("rom_control", e != 2'h3, romc)
        `CHK("i2c_enable", e != 2'h3, i2c)
    endtask : check_mode

    initial begin
        for (int i = 0; i < 9; i++) begin
            @(posedge pclk);
            drv <= (i != 4); lock <= (i >= 5); lvl <= 2'(i % 5); presetn <= 1'b0;
            repeat (2) @(posedge pclk);
            `CHK("pullup_in_reset", 1'b1, pu)
            presetn <= 1'b1;
            @(posedge pclk);
            wait_valid();
            em = (i == 4) ? 2'h3 : ((i >= 5 && lvl != 2'h0) ? 2'h3 : lvl);
            check_mode(em);
            `CHK("boot_time", 1'b1, n >= POR_CYC + T_MODE_CYC && n <= POR_CYC + T_MODE_CYC + 6)
        end
        for (int j = 0; j < 4; j++) begin
            lock <= j[1];
            repeat (2) @(posedge pclk);
            fv <= 1'b1; fs <= j[0];
            @(posedge pclk);
            fv <= 1'b0;
            @(negedge pclk);
            `CHK("flash_block", j == 3, block)
            `CHK("flash_allow", j != 3, allow)
        end
        apb(1'b0, STATUS_OFS, 32'h0);
        `CHK("status_unstable", 1'b0, rd[ST_UNSTAB_BIT])
        `CHK("status_mode", 2'h3, rd[1:0])
        `CHK("status_deny", 1'b1, rd[ST_DENY_BIT])
        apb(1'b1, STATUS_OFS, 32'h100);
        apb(1'b0, STATUS_OFS, 32'h0);
        `CHK("deny_cleared", 1'b0, rd[ST_DENY_BIT])
        apb(1'b0, CAUSE_OFS, 32'h0);
        `CHK("cause_por", 1'b1, rd[CA_POR_BIT])
        apb(1'b0, 12'h00c, 32'h0);
        `CHK("unmapped_err", 1'b1, err)
        lvl <= 2'h1;
        repeat (50) @(posedge pclk);
        `CHK("mode_after_strap_change", 2'h3, mode)
        for (int k = 0; k < 2; k++) begin
            @(posedge pclk);
            wd <= (k == 0); wk <= (k == 1);
            @(posedge pclk);
            wd <= 1'b0; wk <= 1'b0;
            @(negedge pclk);
            `CHK("cpu_reset", 1'b0, cpu_n)
            `CHK("sys_kept", 1'b1, sys_n)
            @(negedge pclk);
            `CHK("cpu_back", 1'b1, cpu_n)
            `CHK("valid_kept", 1'b1, vld)
            check_mode(2'h3);
        end
        // Brown-out with new straps must reselect without a power-on reset.
        lock <= 1'b0;
        @(posedge pclk);
        bo <= 1'b1;
        repeat (10) @(posedge pclk);
        `CHK("bor_hold", 1'b0, sys_n)
        bo <= 1'b0;
        @(posedge pclk);
        wait_valid();
        check_mode(2'h1);
        apb(1'b0, CAUSE_OFS, 32'h0);
        `CHK("cause_bor", 1'b1, rd[CA_BOR_BIT])
        lvl <= 2'h2;
        apb(1'b1, CTRL_OFS, 32'h1);
        repeat (3) @(posedge pclk);
        `CHK("swr_hold", 1'b0, sys_n)
        wait_valid();
        check_mode(2'h2);
        apb(1'b0, CAUSE_OFS, 32'h0);
        `CHK("cause_swr", 1'b1, rd[CA_SWR_BIT])
        apb(1'b1, CAUSE_OFS, 32'h1f);
        apb(1'b0, CAUSE_OFS, 32'h0);
        `CHK("cause_cleared", 5'h00, rd[4:0])
        final_report();
    end

    initial begin
        repeat (40000) @(posedge pclk);
        bad_count++;
        final_report();
    end
endmodule : rms_top_test
`default_nettype wire
